// >>> core/crs_pkg.sv
package crs_pkg;
    // master crystal and sequencing timing
    localparam int CLK_MHZ_X1000 = 100000;
    localparam int RESTART_MS = 8;
    localparam int RESTART_CYCLES = RESTART_MS * CLK_MHZ_X1000;
    localparam int CNT_W = 20;
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(RESTART_CYCLES - 1);
    localparam logic [1:0] PHASE_DIV_LAST = 2'h3;
    localparam logic [1:0] STRETCH_EXTRA = 2'h2;
    // address decode
    localparam logic [4:0] SEL_PROG_LO = 5'h10;
    localparam logic [4:0] SEL_DATA = 5'h00;
    localparam logic [4:0] SEL_IO = 5'h01;
    localparam logic [4:0] SEL_NV = 5'h02;
    localparam logic [15:0] ADDR_IRQ_ID = 16'h0800;
    localparam logic [15:0] ADDR_TICK_CLR = 16'h0801;
    localparam logic [15:0] ADDR_KEY_CLR = 16'h0802;
    localparam logic [15:0] ADDR_BUS_CLR = 16'h0803;
    localparam logic [7:0] FLOAT_OPCODE = 8'h3f;
    localparam logic [15:0] VEC_IRQ = 16'hfff8;
    localparam logic [15:0] VEC_SWI = 16'hfffa;
    localparam int ID_TICK_BIT = 5;
    localparam int ID_KEY_BIT = 6;
    localparam int ID_BUS_BIT = 7;
endpackage : crs_pkg

// >>> core/crs_bus_if.sv
`timescale 1ns/1ps
interface crs_bus_if;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic rd_wr;
    logic valid_access_flag;
    logic [7:0] rdata;
    logic irq_n;
    logic nmi;
    logic cpu_hold_n;
    logic phase_out;
    modport dev (input addr, wdata, rd_wr, valid_access_flag,
                 output rdata, irq_n, nmi, cpu_hold_n, phase_out);
    modport cpu (output addr, wdata, rd_wr, valid_access_flag,
                 input rdata, irq_n, nmi, cpu_hold_n, phase_out);
endinterface : crs_bus_if

// >>> core/crs_sync2.sv
`timescale 1ns/1ps
module crs_sync2 (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic d_in,
    output logic q_out
);
    logic s1;
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s1 <= 1'b0;
            q_out <= 1'b0;
        end else begin
            s1 <= d_in;
            q_out <= s1;
        end
    end
endmodule : crs_sync2

// >>> core/crs_support.sv
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// (RULE_01) bus phase is master clock divided four
// (RULE_02) ready stretch slows bus to about 680kHz; here a stretched cycle is 6 clocks, about 16.7MHz at 100MHz
// (RULE_03) internal switch raises non-maskable interrupt
// (RULE_04) irq is OR of tick, key, bus
// (RULE_05) cpu vectors maskable irq through FFF8/FFF9
// (RULE_06) id read puts source bits on D7..D5
// (RULE_07) requests stay until explicit release access
// (RULE_08) unmapped read returns 3F software interrupt
// (RULE_09) read/write line becomes separate read/write pulses
// (RULE_10) upper address bits make memory selects
// (RULE_11) supply low holds counter, flop, both resets
// (RULE_12) high reset holds keypad, blanks indicator decoder
// (RULE_13) low reset holds cpu, disables decoder
// (RULE_14) low reset holds both adapters
// (RULE_15) supply good starts the 8ms counter
// (RULE_16) full count captures supply, releases resets
// (RULE_17) tick clear access; next full count re-raises
// (RULE_18) supply fall forces reset, clears counter
// (RULE_19) valid access with no select restarts
// (RULE_20) after watchdog restart resets release 8ms later
// (RULE_21) supply good synchronised before capture
// (RULE_22) id bits live, unused lines zero
module crs_support
    import crs_pkg::*;
#(
    // full count of the restart counter; a bench may shorten it
    parameter int RESTART_COUNT = RESTART_CYCLES
)
(
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic clk_en_in,
    input wire logic supply_good_in,
    input wire logic memory_ready_stretch_in,
    input wire logic nmi_switch_in,
    input wire logic keypad_request_in,
    input wire logic bus_adapter_request_in,
    crs_bus_if.dev bus,
    output logic power_up_hold_out,
    output logic power_up_hold_n_out,
    output logic stretched_bus_clock_out,
    output logic read_pulse_n_out,
    output logic write_pulse_n_out,
    output logic prog_sel_n_out,
    output logic data_sel_n_out,
    output logic nv_sel_n_out,
    output logic io_sel_n_out,
    output logic [13:0] inst_addr_out,
    output logic [2:0] irq_pending_out
);
    logic sg_sync;
    logic [CNT_W-1:0] cnt;
    logic restart_q;
    logic [1:0] div;
    logic [1:0] stretch;
    logic phase;
    logic tick_req;
    logic key_req;
    logic bus_req;
    logic nmi_s;
    logic key_s;
    logic busr_s;
    logic next_full;
    logic sel_any;
    logic watchdog_hit;
    logic cycle_end;
    logic mr_s;
    logic restart_rst_n;
    localparam logic [CNT_W-1:0] FULL_AT = CNT_W'(RESTART_COUNT - 1);

    // (RULE_21) two-stage supply sync
    crs_sync2 u_sg (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .d_in(supply_good_in), .q_out(sg_sync));
    crs_sync2 u_nmi (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .d_in(nmi_switch_in), .q_out(nmi_s));
    crs_sync2 u_key (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .d_in(keypad_request_in), .q_out(key_s));
    crs_sync2 u_bus (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .d_in(bus_adapter_request_in), .q_out(busr_s));
    crs_sync2 u_mr (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .d_in(memory_ready_stretch_in), .q_out(mr_s));

    function automatic logic [3:0] decode_sel(input logic [4:0] hi);
        logic [3:0] s;
        s = 4'h0;
        if (hi >= SEL_PROG_LO) s[0] = 1'b1;
        if (hi == SEL_DATA) s[1] = 1'b1;
        if (hi == SEL_NV) s[2] = 1'b1;
        if (hi == SEL_IO) s[3] = 1'b1;
        return s;
    endfunction : decode_sel

    // (RULE_10) upper bits decode selects
    assign sel_any = |decode_sel(bus.addr[15:11]);
    assign cycle_end = (div == PHASE_DIV_LAST) && (stretch == 2'h0);
    // (RULE_19) valid access, nothing selected
    assign watchdog_hit = restart_q && bus.valid_access_flag && phase && !sel_any;
    assign next_full = (cnt == FULL_AT);
    // (RULE_18) supply fall resets restart logic at once
    // the synced copy only gates release, so a dying rail never waits for a clock edge
    assign restart_rst_n = rstn_in && supply_good_in;

    // (RULE_01) divide by four phase
    // (RULE_02) stretch adds wait cycles per phase
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            div <= 2'h0;
            stretch <= 2'h0;
            phase <= 1'b0;
        end else if (clk_en_in) begin
            if (stretch != 2'h0) begin
                stretch <= stretch - 2'h1;
            end else begin
                div <= div + 2'h1;
                if (div == 2'h1) phase <= 1'b1;
                if (div == PHASE_DIV_LAST) begin
                    phase <= 1'b0;
                    if (mr_s) stretch <= STRETCH_EXTRA;
                end
            end
        end
    end

    // (RULE_11) supply low holds counter
    // (RULE_15) counting starts on supply good
    // (RULE_18) supply fall clears counter
    always_ff @(posedge core_clk_in or negedge restart_rst_n) begin
        if (!restart_rst_n) begin
            cnt <= '0;
        end else if (clk_en_in) begin
            if (!sg_sync || watchdog_hit || next_full) cnt <= '0;
            else cnt <= cnt + CNT_W'(1);
        end
    end

    // (RULE_16) capture supply at full count
    // (RULE_20) watchdog restart then re-release
    always_ff @(posedge core_clk_in or negedge restart_rst_n) begin
        if (!restart_rst_n) begin
            restart_q <= 1'b0;
        end else if (clk_en_in) begin
            if (!sg_sync || watchdog_hit) restart_q <= 1'b0;
            else if (next_full) restart_q <= sg_sync;
        end
    end

    // (RULE_12) high reset polarity
    // (RULE_13) low reset to cpu
    // (RULE_14) low reset to adapters
    always_ff @(posedge core_clk_in or negedge restart_rst_n) begin
        if (!restart_rst_n) begin
            power_up_hold_out <= 1'b1;
            power_up_hold_n_out <= 1'b0;
            bus.cpu_hold_n <= 1'b0;
        end else if (clk_en_in) begin
            power_up_hold_out <= !restart_q;
            power_up_hold_n_out <= restart_q;
            bus.cpu_hold_n <= restart_q;
        end
    end

    // (RULE_17) tick set wins over clear
    // (RULE_07) requests held until release
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tick_req <= 1'b0;
            key_req <= 1'b0;
            bus_req <= 1'b0;
        end else if (clk_en_in) begin
            if (!restart_q) tick_req <= 1'b0;
            else if (next_full) tick_req <= 1'b1;
            else if (bus.valid_access_flag && phase && bus.addr == ADDR_TICK_CLR) tick_req <= 1'b0;
            if (key_s) key_req <= 1'b1;
            else if (bus.valid_access_flag && phase && bus.addr == ADDR_KEY_CLR) key_req <= 1'b0;
            if (busr_s) bus_req <= 1'b1;
            else if (bus.valid_access_flag && phase && bus.addr == ADDR_BUS_CLR) bus_req <= 1'b0;
        end
    end

    // (RULE_04) wired OR onto irq
    // (RULE_03) nmi from switch
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bus.irq_n <= 1'b1;
            bus.nmi <= 1'b0;
            irq_pending_out <= 3'h0;
        end else if (clk_en_in) begin
            bus.irq_n <= !(tick_req || key_req || bus_req);
            bus.nmi <= nmi_s && restart_q;
            irq_pending_out <= {bus_req, key_req, tick_req};
        end
    end

    // (RULE_06) identity bits on D7..D5
    // (RULE_22) live bits, others zero
    // (RULE_08) unmapped read floats to 3F
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bus.rdata <= FLOAT_OPCODE;
        end else if (clk_en_in) begin
            if (bus.addr == ADDR_IRQ_ID) begin
                bus.rdata <= 8'h00;
                bus.rdata[ID_TICK_BIT] <= tick_req;
                bus.rdata[ID_KEY_BIT] <= key_req;
                bus.rdata[ID_BUS_BIT] <= bus_req;
            end else begin
                bus.rdata <= FLOAT_OPCODE;
            end
        end
    end

    // (RULE_09) read/write pulses from rd_wr
    // (RULE_13) decoder idle while held
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            read_pulse_n_out <= 1'b1;
            write_pulse_n_out <= 1'b1;
            {io_sel_n_out, nv_sel_n_out, data_sel_n_out, prog_sel_n_out} <= 4'hf;
            inst_addr_out <= 14'h0000;
            stretched_bus_clock_out <= 1'b0;
            bus.phase_out <= 1'b0;
        end else if (clk_en_in) begin
            read_pulse_n_out <= !(restart_q && bus.valid_access_flag && phase && bus.rd_wr);
            write_pulse_n_out <= !(restart_q && bus.valid_access_flag && phase && !bus.rd_wr);
            if (restart_q && bus.valid_access_flag)
                {io_sel_n_out, nv_sel_n_out, data_sel_n_out, prog_sel_n_out} <= ~decode_sel(bus.addr[15:11]);
            else
                {io_sel_n_out, nv_sel_n_out, data_sel_n_out, prog_sel_n_out} <= 4'hf;
            inst_addr_out <= bus.addr[13:0];
            stretched_bus_clock_out <= phase;
            bus.phase_out <= phase && !cycle_end;
        end
    end
endmodule : crs_support

// >>> core/crs_cpu_end.sv
`timescale 1ns/1ps
// processor side: issues accesses from a user port, vectors on interrupts
module crs_cpu_end
    import crs_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic clk_en_in,
    input wire logic req_in,
    input wire logic req_read_in,
    input wire logic [15:0] req_addr_in,
    input wire logic [7:0] req_wdata_in,
    crs_bus_if.cpu bus,
    output logic done_out,
    output logic [7:0] rdata_out,
    output logic [15:0] vector_out,
    output logic vector_valid_out
);
    typedef enum logic [1:0] {CRS_IDLE, CRS_ACC, CRS_WAIT} crs_state_t;
    crs_state_t state;
    logic irq_seen;

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= CRS_IDLE;
            bus.addr <= 16'h0000;
            bus.wdata <= 8'h00;
            bus.rd_wr <= 1'b1;
            bus.valid_access_flag <= 1'b0;
            done_out <= 1'b0;
            rdata_out <= 8'h00;
        end else if (clk_en_in) begin
            done_out <= 1'b0;
            if (!bus.cpu_hold_n) begin
                state <= CRS_IDLE;
                bus.valid_access_flag <= 1'b0;
            end else begin
                unique case (state)
                    CRS_IDLE: if (req_in) begin
                        bus.addr <= req_addr_in;
                        bus.wdata <= req_wdata_in;
                        bus.rd_wr <= req_read_in;
                        bus.valid_access_flag <= 1'b1;
                        state <= CRS_ACC;
                    end
                    CRS_ACC: if (bus.phase_out) state <= CRS_WAIT;
                    CRS_WAIT: if (!bus.phase_out) begin
                        rdata_out <= bus.rdata;
                        done_out <= 1'b1;
                        bus.valid_access_flag <= 1'b0;
                        state <= CRS_IDLE;
                    end
                endcase
            end
        end
    end

    // (RULE_05) maskable irq vectors to FFF8
    // (RULE_08) 3F opcode vectors to FFFA
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_seen <= 1'b0;
            vector_out <= 16'h0000;
            vector_valid_out <= 1'b0;
        end else if (clk_en_in) begin
            vector_valid_out <= 1'b0;
            if (done_out && bus.rd_wr && rdata_out == FLOAT_OPCODE) begin
                vector_out <= VEC_SWI;
                vector_valid_out <= 1'b1;
            end else if (!bus.irq_n && !irq_seen && bus.cpu_hold_n) begin
                vector_out <= VEC_IRQ;
                vector_valid_out <= 1'b1;
            end
            irq_seen <= !bus.irq_n;
        end
    end
endmodule : crs_cpu_end

// >>> tb/crs_support_props.sv
`timescale 1ns/1ps
module crs_support_props
    import crs_pkg::*;
#(
    parameter int RESTART_COUNT = RESTART_CYCLES
)
(
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic supply_good_in,
    input wire logic [2:0] irq_pending_out,
    input wire logic [15:0] addr,
    input wire logic valid_access_flag,
    input wire logic rd_wr,
    input wire logic [7:0] rdata,
    input wire logic irq_n,
    input wire logic cpu_hold_n,
    input wire logic phase_out
);
    logic [19:0] good_cnt;
    logic id_rd;
    logic stray;
    assign id_rd = valid_access_flag && rd_wr && phase_out && cpu_hold_n && addr == ADDR_IRQ_ID;
    assign stray = valid_access_flag && phase_out && cpu_hold_n && addr[15:11] > SEL_NV && addr[15:11] < SEL_PROG_LO;
    // saturates so a long good supply never wraps back under the release figure
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            good_cnt <= '0;
        end else if (!supply_good_in) begin
            good_cnt <= '0;
        end else if (good_cnt != '1) begin
            good_cnt <= good_cnt + 20'h1;
        end
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    a_supply_fall_hold: assert property ($fell(supply_good_in) |-> ##[1:4] !cpu_hold_n)
        else $error("hold not forced after supply fall");
    a_low_supply_hold: assert property (!supply_good_in [*5] |-> !cpu_hold_n)
        else $error("released while supply low");
    a_release_count: assert property ($rose(cpu_hold_n) |-> good_cnt >= 20'(RESTART_COUNT))
        else $error("released before full count");
    a_stray_restart: assert property (stray |-> ##[1:4] !cpu_hold_n)
        else $error("stray access did not restart");
    a_irq_or_sources: assert property ((cpu_hold_n && |irq_pending_out) [*2] |-> !irq_n)
        else $error("irq line high with source pending");
    a_key_release: assert property ($fell(irq_pending_out[1]) && cpu_hold_n && $past(cpu_hold_n) |->
        $past(addr) == ADDR_KEY_CLR || $past(addr, 2) == ADDR_KEY_CLR)
        else $error("key request dropped without clear access");
    a_phase_div: assert property ($rose(phase_out) |=> (!$rose(phase_out)) [*3])
        else $error("bus phase faster than quarter clock");
    a_id_bits: assert property (addr == ADDR_IRQ_ID |=> rdata == {irq_pending_out, 5'h00})
        else $error("id read bits wrong");
    a_float_read: assert property (addr != ADDR_IRQ_ID |=> rdata == FLOAT_OPCODE)
        else $error("non id read not floating opcode");
    c_release: cover property ($rose(cpu_hold_n));
    c_tick_clear: cover property ($fell(irq_pending_out[0]));
    c_id_read: cover property (id_rd);
endmodule : crs_support_props

// >>> tb/cpu_reset_and_irq_support_tb.sv
`timescale 1ns/1ps
module cpu_reset_and_irq_support_tb;
    import crs_pkg::*;
    logic clk, rstn, good, stretch, nmi_sw, key_rq, bus_rq, req, req_rd, hold, hold_n, phs, rd_n, wr_n;
    logic p_sel, d_sel, n_sel, i_sel, done, rd_last, wr_last, sel_seen;
    logic [15:0] req_addr, a;
    logic [7:0] req_wd, rd_o;
    logic [13:0] ia, ia_seen;
    logic [2:0] pend;
    logic [31:0] v;
    int bad_count, checks_done, rd_cnt, wr_cnt, n, seed, irq_cnt, swi_cnt;
    logic [15:0] vec;
    logic vec_v;
    // restart count cut down so each 8ms wait stays a few thousand cycles
    localparam int TB_RESTART = 3000;
    crs_bus_if bus_if ();
    crs_support #(.RESTART_COUNT(TB_RESTART)) u_crs_support (.core_clk_in(clk), .rstn_in(rstn), .clk_en_in(1'b1),
        .supply_good_in(good),
        .memory_ready_stretch_in(stretch), .nmi_switch_in(nmi_sw), .keypad_request_in(key_rq),
        .bus_adapter_request_in(bus_rq), .bus(bus_if), .power_up_hold_out(hold), .power_up_hold_n_out(hold_n),
        .stretched_bus_clock_out(phs), .read_pulse_n_out(rd_n), .write_pulse_n_out(wr_n), .prog_sel_n_out(p_sel),
        .data_sel_n_out(d_sel), .nv_sel_n_out(n_sel), .io_sel_n_out(i_sel), .inst_addr_out(ia),
        .irq_pending_out(pend));
    crs_cpu_end u_crs_cpu_end (.core_clk_in(clk), .rstn_in(rstn), .clk_en_in(1'b1), .req_in(req),
        .req_read_in(req_rd), .req_addr_in(req_addr), .req_wdata_in(req_wd), .bus(bus_if), .done_out(done),
        .rdata_out(rd_o), .vector_out(vec), .vector_valid_out(vec_v));
    crs_support_props #(.RESTART_COUNT(TB_RESTART)) u_crs_support_props (.core_clk_in(clk), .rstn_in(rstn),
        .supply_good_in(good),
        .irq_pending_out(pend), .addr(bus_if.addr), .valid_access_flag(bus_if.valid_access_flag),
        .rd_wr(bus_if.rd_wr), .rdata(bus_if.rdata), .irq_n(bus_if.irq_n), .cpu_hold_n(bus_if.cpu_hold_n),
        .phase_out(bus_if.phase_out));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // strobe edges and the address seen while a strobe is low
    always @(posedge clk) begin
        if (rd_n === 1'b0 && rd_last === 1'b1) rd_cnt++;
        if (wr_n === 1'b0 && wr_last === 1'b1) wr_cnt++;
        if (rd_n === 1'b0 || wr_n === 1'b0) ia_seen = ia;
        if (rd_n === 1'b0 || wr_n === 1'b0) sel_seen = d_sel;
        if (vec_v === 1'b1 && vec === VEC_SWI) swi_cnt++;
        if (vec_v === 1'b1 && vec === VEC_IRQ) irq_cnt++;
        rd_last = rd_n;
        wr_last = wr_n;
    end
    task automatic stop_test();
        $display("checks %0d bad %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s exp %h got %h", w, e, g);
        end
    endtask : chk
    task automatic limit(input int k, input int lim, input string w);
        if (k >= lim) begin
            bad_count++;
            $display("BAD %s exp done got timeout", w);
            stop_test();
        end
    endtask : limit
    task automatic access(input logic rd, input logic [15:0] ad, input logic [7:0] d);
        @(posedge clk);
        req <= 1'b1;
        req_rd <= rd;
        req_addr <= ad;
        req_wd <= d;
        @(posedge clk);
        req <= 1'b0;
        // a watchdog restart ends the access without done
        for (n = 0; n < 40 && done !== 1'b1 && hold_n !== 1'b0; n++) @(posedge clk);
        limit(n, 40, "done");
    endtask : access
    task automatic period(input logic s);
        int first;
        logic last;
        stretch <= s;
        repeat (12) @(posedge clk);
        first = -1;
        n = 0;
        last = phs;
        for (int i = 0; i < 40 && n == 0; i++) begin
            @(posedge clk);
            if (phs === 1'b1 && last === 1'b0 && first >= 0) n = i - first;
            if (phs === 1'b1 && last === 1'b0 && first < 0) first = i;
            last = phs;
        end
    endtask : period
    initial begin
        seed = 32'h91ea0404;
        {rstn, good, stretch, nmi_sw, key_rq, bus_rq, req, req_rd, req_wd, req_addr} = '0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (20) @(posedge clk);
        chk("hold", 16'h1, {15'h0, hold});
        chk("hold_n", 16'h0, {15'h0, hold_n});
        chk("selects", 16'hf, {12'h0, p_sel, d_sel, n_sel, i_sel});
        $display("test hold done");
        good <= 1'b1;
        for (n = 0; n < TB_RESTART + 100 && hold_n !== 1'b1; n++) @(posedge clk);
        limit(n, TB_RESTART + 100, "release");
        chk("count", 16'h1, {15'h0, n >= TB_RESTART});
        chk("hold_off", 16'h0, {15'h0, hold});
        $display("test release done");
        period(1'b0);
        chk("period", 16'h4, n[15:0]);
        period(1'b1);
        chk("stretched", 16'h6, n[15:0]);
        nmi_sw <= 1'b1;
        repeat (6) @(posedge clk);
        chk("nmi", 16'h1, {15'h0, bus_if.nmi});
        nmi_sw <= 1'b0;
        $display("test clocks done");
        for (int k = 1; k < 3; k++) begin
            irq_cnt = 0;
            key_rq <= (k == 1);
            bus_rq <= (k == 2);
            repeat (8) @(posedge clk);
            key_rq <= 1'b0;
            bus_rq <= 1'b0;
            chk("irq_n", 16'h0, {15'h0, bus_if.irq_n});
            chk("irq_vec", 16'h1, irq_cnt[15:0]);
            access(1'b1, ADDR_IRQ_ID, 8'h00);
            chk("id_bits", 16'(1 << (k + 5)), {8'h0, rd_o & 8'hdf});
            access(1'b0, ADDR_IRQ_ID + 16'(k + 1), 8'h00);
            repeat (4) @(posedge clk);
            chk("pending", 16'h0, {15'h0, pend[k]});
        end
        $display("test sources done");
        for (int i = 0; i < 12; i++) begin
            v = $random(seed);
            a = v[16] ? {1'b1, v[14:0]} : {5'h00, v[10:0]};
            rd_cnt = 0;
            wr_cnt = 0;
            swi_cnt = 0;
            stretch <= v[17];
            access(v[18], a, v[7:0]);
            chk("read_pulse", {15'h0, v[18]}, rd_cnt[15:0]);
            chk("wr_strb", {15'h0, !v[18]}, wr_cnt[15:0]);
            chk("inst_addr", {2'h0, a[13:0]}, {2'h0, ia_seen});
            chk("data_sel", {15'h0, v[16]}, {15'h0, sel_seen});
            // the vector follows done by one edge
            repeat (2) @(posedge clk);
            chk("swi_vec", {15'h0, v[18]}, swi_cnt[15:0]);
        end
        $display("test random done");
        for (n = 0; n < TB_RESTART + 100 && pend[0] !== 1'b1; n++) @(posedge clk);
        limit(n, TB_RESTART + 100, "tick");
        access(1'b0, ADDR_TICK_CLR, 8'h00);
        repeat (4) @(posedge clk);
        chk("tick_clr", 16'h0, {15'h0, pend[0]});
        $display("test tick done");
        access(1'b1, 16'h6000, 8'h00);
        repeat (4) @(posedge clk);
        chk("restart", 16'h0, {15'h0, hold_n});
        chk("float", {8'h0, FLOAT_OPCODE}, {8'h0, bus_if.rdata});
        for (n = 0; n < TB_RESTART + 100 && hold_n !== 1'b1; n++) @(posedge clk);
        limit(n, TB_RESTART + 100, "rerelease");
        chk("rerelease", 16'h1, {15'h0, n >= TB_RESTART - 10});
        // supply fall must hold at once, not after the synchroniser
        good <= 1'b0;
        @(posedge clk);
        chk("supply_low", 16'h1, {15'h0, hold});
        $display("test restart done");
        stop_test();
    end
endmodule : cpu_reset_and_irq_support_tb
